// *** hw/vmam_pkg.sv ***
package vmam_pkg;
  localparam logic [15:0] IO_INDEX_PORT = 16'h03ce;
  localparam logic [15:0] IO_DATA_PORT = 16'h03cf;
  localparam logic [7:0] IDX_PRIMARY = 8'h09;
  localparam logic [7:0] IDX_ALTERNATE = 8'h0a;
  localparam logic [7:0] IDX_MEMSIZE = 8'h0b;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [6:0] OFFSET_RESET = 7'h00;
  localparam logic [5:0] MEMSIZE_HI_RESET = 6'h00;
  localparam int MS_ROM_OUT = 0;
  localparam int MS_WIDE_BUS = 2;
  localparam int MS_ALT_EN = 3;
  localparam int MS_MAP_LO = 4;
  localparam int MS_SIZE_LO = 6;
  localparam int MISC2_COMPAT = 1;
  localparam int GR6_MAP_LO = 2;
  localparam int MISCOUT_PAGE = 5;
  localparam logic [3:0] ROM_BASE_HI = 4'hc;
  localparam logic [19:0] ROM_END = 20'hc7fff;

  typedef enum logic [1:0] {
    VMAM_BYTE = 2'b00,
    VMAM_WORD = 2'b01,
    VMAM_DWORD = 2'b10
  } vmam_width_t;

  typedef enum logic [1:0] {
    VMAM_STD256 = 2'b00,
    VMAM_EXT256 = 2'b01,
    VMAM_EXT512 = 2'b10,
    VMAM_EXT1024 = 2'b11
  } vmam_size_t;

  typedef enum logic [1:0] {
    VMAM_WIN_A0_128K = 2'b00,
    VMAM_WIN_A0_64K = 2'b01,
    VMAM_WIN_B0_32K = 2'b10,
    VMAM_WIN_B8_32K = 2'b11
  } vmam_win_t;
endpackage

// *** hw/vmam_pin_sync.sv ***
`timescale 1ns/10ps
module vmam_pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinStable
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] stable;
  } vmam_sync_t;

  vmam_sync_t st;
  vmam_sync_t next_st;

  // no reset: the chain must keep sampling while reset is held
  always_comb begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.stable[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    st <= next_st;
  end

  assign pinStable = st.stable;
endmodule

// *** hw/vmam_window.sv ***
`timescale 1ns/10ps
module vmam_window (
  input wire logic [19:0] sysAddr,
  input wire logic [6:0] primaryOffset,
  input wire logic [6:0] alternateOffset,
  input wire logic altEnable,
  input wire logic extendedMap,
  input wire logic [1:0] mapSelect,
  input wire logic [1:0] windowSelect,
  output logic hit,
  output logic useAlt,
  output logic [19:0] relAddr,
  output logic [19:0] linAddr
);
  logic [7:0] segSum;
  logic [6:0] selOffset;
  logic offsetOn;

  always_comb begin
    hit = 1'b0;
    relAddr = sysAddr;
    useAlt = 1'b0;
    if (mapSelect != 2'b00) begin
      // linear map from address zero
      case (mapSelect)
        2'b01: hit = (sysAddr[19:18] == 2'b00);
        2'b10: hit = ~sysAddr[19];
        default: hit = 1'b1;
      endcase
    end else begin
      case (vmam_pkg::vmam_win_t'(windowSelect))
        vmam_pkg::VMAM_WIN_A0_128K: begin
          hit = (sysAddr[19:17] == 3'h5);
          relAddr = {3'h0, sysAddr[16:0]};
          useAlt = ~sysAddr[16];
        end
        vmam_pkg::VMAM_WIN_A0_64K: begin
          hit = (sysAddr[19:16] == 4'ha);
          relAddr = {4'h0, sysAddr[15:0]};
          useAlt = ~sysAddr[15];
        end
        vmam_pkg::VMAM_WIN_B0_32K: begin
          hit = (sysAddr[19:15] == 5'h16);
          relAddr = {5'h00, sysAddr[14:0]};
        end
        default: begin
          hit = (sysAddr[19:15] == 5'h17);
          relAddr = {5'h00, sysAddr[14:0]};
        end
      endcase
    end
    useAlt = useAlt & altEnable & extendedMap & (mapSelect == 2'b00);
  end

  assign offsetOn = extendedMap & (mapSelect == 2'b00);
  assign selOffset = useAlt ? alternateOffset : primaryOffset;
  assign segSum = {1'b0, relAddr[18:12]} + {1'b0, selOffset};
  assign linAddr = offsetOn ? {segSum, relAddr[11:0]} : relAddr;
endmodule

// *** hw/vmam_mapper.sv ***
`timescale 1ns/10ps
module vmam_mapper (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic ioRdHit,
  input wire logic [19:0] hostAddr,
  input wire logic crtCycle,
  input wire logic [17:0] crtCharacterAddress,
  input wire logic [1:0] widthMode,
  input wire logic [7:0] secondMiscControl,
  input wire logic [7:0] graphicsMisc,
  input wire logic [7:0] miscOutput,
  input wire logic planarGraphics,
  input wire logic chainFour,
  input wire logic dramRowPhase,
  input wire logic [1:0] memoryDataBus,
  output logic [17:0] videoRamAddress,
  output logic ninthDramAddressOut,
  output logic hostMemHit,
  output logic wideBusSelectN,
  output logic biosRomSelect
);
  typedef struct packed {
    logic [7:0] index;
    logic [6:0] primary;
    logic [6:0] alt;
    logic [7:0] memSize;
    logic [7:0] rdData;
    logic rdHit;
    logic [17:0] vramAddr;
    logic ninth;
    logic wideN;
    logic hostHit;
    logic romSel;
  } vmam_state_t;

  vmam_state_t st;
  vmam_state_t next_st;

  logic [1:0] strapStable;
  logic winHit;
  logic useAlt;
  logic [19:0] relAddr;
  logic [19:0] linAddr;
  logic compatMap;
  logic extendedMap;
  logic [1:0] sizeSel;
  logic invertedPageSelect;
  logic pageSubst;
  logic [17:0] ma;
  logic isBig;
  logic is512;
  logic isStd;
  logic ninthBit;
  logic romRange;

  vmam_pin_sync #(
    .WIDTH(2)
  ) u_strap (
    .sys_clk(sys_clk),
    .pinIn(memoryDataBus),
    .pinStable(strapStable)
  );

  assign compatMap = secondMiscControl[vmam_pkg::MISC2_COMPAT];
  assign sizeSel = st.memSize[vmam_pkg::MS_SIZE_LO +: 2];
  // standard table wherever compatibility is forced or size bits read 00
  assign extendedMap = ~compatMap & (sizeSel != vmam_pkg::VMAM_STD256);
  assign isStd = ~extendedMap;
  assign is512 = extendedMap & (sizeSel == vmam_pkg::VMAM_EXT512);
  assign isBig = extendedMap & (sizeSel == vmam_pkg::VMAM_EXT1024);
  assign invertedPageSelect = ~miscOutput[vmam_pkg::MISCOUT_PAGE];
  assign pageSubst = |graphicsMisc[vmam_pkg::GR6_MAP_LO +: 2];

  vmam_window u_window (
    .sysAddr(hostAddr),
    .primaryOffset(st.primary),
    .alternateOffset(st.alt),
    .altEnable(st.memSize[vmam_pkg::MS_ALT_EN]),
    .extendedMap(extendedMap),
    .mapSelect(st.memSize[vmam_pkg::MS_MAP_LO +: 2]),
    .windowSelect(graphicsMisc[vmam_pkg::GR6_MAP_LO +: 2]),
    .hit(winHit),
    .useAlt(useAlt),
    .relAddr(relAddr),
    .linAddr(linAddr)
  );

  // per-plane address; planes share it, chaining picks the plane elsewhere
  always_comb begin
    ma = '0;
    case (vmam_pkg::vmam_width_t'(widthMode))
      vmam_pkg::VMAM_WORD: begin
        if (crtCycle) begin
          ma = {crtCharacterAddress[16:0],
                isBig ? crtCharacterAddress[17] : crtCharacterAddress[15]};
          if (!isBig) begin
            ma[17] = 1'b0;
            ma[16] = is512 & crtCharacterAddress[16];
          end
        end else begin
          ma = {linAddr[17:1], isBig ? linAddr[18] : linAddr[16]};
          if (!isBig) begin
            ma[17] = 1'b0;
            ma[16] = is512 & linAddr[17];
          end
          if (pageSubst) begin
            ma[0] = invertedPageSelect;
          end
        end
      end
      vmam_pkg::VMAM_DWORD: begin
        if (crtCycle) begin
          ma[17:2] = crtCharacterAddress[15:0];
          ma[1:0] = isBig ? crtCharacterAddress[17:16] :
                    isStd ? crtCharacterAddress[13:12] : crtCharacterAddress[15:14];
          if (!isBig) begin
            ma[17] = 1'b0;
            ma[16] = is512 & crtCharacterAddress[16];
          end
        end else begin
          ma[17:2] = linAddr[17:2];
          ma[1:0] = isBig ? linAddr[19:18] : isStd ? linAddr[15:14] : linAddr[17:16];
          if (!isBig) begin
            ma[17] = 1'b0;
            ma[16] = is512 & linAddr[18];
          end
        end
      end
      default: begin
        ma = crtCycle ? crtCharacterAddress : linAddr[17:0];
        if (!isBig) begin
          ma[17] = 1'b0;
          ma[16] = is512 & ma[16];
        end
      end
    endcase
    if (!is512 && !isBig) begin
      // 64K per plane; chained mode 13 reaches only 64K here
      ma[17:16] = 2'b00;
    end
  end

  always_comb begin
    ninthBit = 1'b0;
    if (is512) begin
      ninthBit = ma[16];
    end else if (isBig) begin
      ninthBit = dramRowPhase ? ma[17] : ma[16];
    end
  end

  assign romRange = (hostAddr[19:16] == vmam_pkg::ROM_BASE_HI) &&
                    (hostAddr <= vmam_pkg::ROM_END);

  always_comb begin
    next_st = st;
    next_st.rdHit = 1'b0;
    if (ioWrite && ioAddr == vmam_pkg::IO_INDEX_PORT) begin
      next_st.index = ioWrData;
    end
    if (ioWrite && ioAddr == vmam_pkg::IO_DATA_PORT) begin
      case (st.index)
        vmam_pkg::IDX_PRIMARY: next_st.primary = ioWrData[6:0];
        vmam_pkg::IDX_ALTERNATE: next_st.alt = ioWrData[6:0];
        vmam_pkg::IDX_MEMSIZE: next_st.memSize = ioWrData;
        default: next_st.index = st.index;
      endcase
    end
    if (ioRead && ioAddr == vmam_pkg::IO_DATA_PORT) begin
      // other indexes belong to neighbouring blocks and are not claimed
      case (st.index)
        vmam_pkg::IDX_PRIMARY: begin
          next_st.rdData = {1'b0, st.primary};
          next_st.rdHit = 1'b1;
        end
        vmam_pkg::IDX_ALTERNATE: begin
          next_st.rdData = {1'b0, st.alt};
          next_st.rdHit = 1'b1;
        end
        vmam_pkg::IDX_MEMSIZE: begin
          next_st.rdData = st.memSize;
          next_st.rdHit = 1'b1;
        end
        default: next_st.rdData = 8'h00;
      endcase
    end else if (ioRead && ioAddr == vmam_pkg::IO_INDEX_PORT) begin
      next_st.rdData = st.index;
      next_st.rdHit = 1'b1;
    end
    next_st.vramAddr = ma;
    next_st.ninth = ninthBit;
    next_st.hostHit = winHit & ~crtCycle;
    next_st.wideN = ~(winHit & ~crtCycle & st.memSize[vmam_pkg::MS_WIDE_BUS]
                      & ~planarGraphics);
    next_st.romSel = romRange & ~st.memSize[vmam_pkg::MS_ROM_OUT];
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
      st.index <= vmam_pkg::INDEX_RESET;
      st.primary <= vmam_pkg::OFFSET_RESET;
      st.alt <= vmam_pkg::OFFSET_RESET;
      st.memSize[7:2] <= vmam_pkg::MEMSIZE_HI_RESET;
      // pull-up reads high and must store 0, hence the inversion
      st.memSize[1:0] <= ~strapStable;
      st.wideN <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign ioRdData = st.rdData;
  assign ioRdHit = st.rdHit;
  assign videoRamAddress = st.vramAddr;
  assign ninthDramAddressOut = st.ninth;
  assign hostMemHit = st.hostHit;
  assign wideBusSelectN = st.wideN;
  assign biosRomSelect = st.romSel;

  property p_alt_gated;
    @(posedge sys_clk) disable iff (!rst_n)
    !st.memSize[vmam_pkg::MS_ALT_EN] |-> !useAlt;
  endproperty
  a_alt_gated: assert property (p_alt_gated) else $error("alternate offset used while disabled");

  property p_primary_default;
    @(posedge sys_clk) disable iff (!rst_n)
    (extendedMap && st.memSize[5:4] == 2'b00 && !useAlt)
      |-> linAddr[19:12] == {1'b0, relAddr[18:12]} + {1'b0, st.primary};
  endproperty
  a_primary_default: assert property (p_primary_default) else $error("primary offset not added");

  property p_alt_sum;
    @(posedge sys_clk) disable iff (!rst_n)
    useAlt |-> linAddr[19:12] == {1'b0, relAddr[18:12]} + {1'b0, st.alt};
  endproperty
  a_alt_sum: assert property (p_alt_sum) else $error("alternate offset sum wrong");

  property p_split64;
    @(posedge sys_clk) disable iff (!rst_n)
    (extendedMap && st.memSize[5:3] == 3'b001 && graphicsMisc[3:2] == 2'b01 && winHit)
      |-> useAlt == ~hostAddr[15];
  endproperty
  a_split64: assert property (p_split64) else $error("64K split window wrong");

  property p_split128;
    @(posedge sys_clk) disable iff (!rst_n)
    (extendedMap && st.memSize[5:3] == 3'b001 && graphicsMisc[3:2] == 2'b00 && winHit)
      |-> useAlt == ~hostAddr[16];
  endproperty
  a_split128: assert property (p_split128) else $error("128K split window wrong");

  property p_std_top_zero;
    @(posedge sys_clk) disable iff (!rst_n)
    isStd |=> videoRamAddress[17:16] == 2'b00;
  endproperty
  a_std_top_zero: assert property (p_std_top_zero) else $error("standard RAM bits 17:16 set");

  property p_ninth_unused;
    @(posedge sys_clk) disable iff (!rst_n)
    (!is512 && !isBig) |=> !ninthDramAddressOut;
  endproperty
  a_ninth_unused: assert property (p_ninth_unused) else $error("ninth address active at 256K");

  property p_wide_planar;
    @(posedge sys_clk) disable iff (!rst_n)
    !wideBusSelectN |-> $past(!planarGraphics) && $past(st.memSize[2]);
  endproperty
  a_wide_planar: assert property (p_wide_planar) else $error("wide bus select in planar mode");

  property p_rom_out;
    @(posedge sys_clk) disable iff (!rst_n)
    st.memSize[vmam_pkg::MS_ROM_OUT] |=> !biosRomSelect;
  endproperty
  a_rom_out: assert property (p_rom_out) else $error("ROM decoded while mapped out");

  property p_reset_clear;
    @(posedge sys_clk)
    $rose(rst_n) |-> st.primary == 7'h00 && st.alt == 7'h00 && st.memSize[7:2] == 6'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("offsets not cleared by reset");

  property p_chain_64k;
    @(posedge sys_clk) disable iff (!rst_n)
    (chainFour && isStd) |=> videoRamAddress[17:16] == 2'b00;
  endproperty
  a_chain_64k: assert property (p_chain_64k) else $error("chain exceeds 64K");

  property p_compat_std;
    @(posedge sys_clk) disable iff (!rst_n)
    compatMap |-> isStd && !is512 && !isBig;
  endproperty
  a_compat_std: assert property (p_compat_std) else $error("compat not standard");

  property p_size_decode;
    @(posedge sys_clk) disable iff (!rst_n)
    (!compatMap && sizeSel == 2'b10) |-> is512 && !isBig;
  endproperty
  a_size_decode: assert property (p_size_decode) else $error("512K decode wrong");

  property p_bank_select;
    @(posedge sys_clk) disable iff (!rst_n)
    is512 |=> ninthDramAddressOut == videoRamAddress[16];
  endproperty
  a_bank_select: assert property (p_bank_select) else $error("bank select wrong");

  property p_a8_row;
    @(posedge sys_clk) disable iff (!rst_n)
    (isBig && dramRowPhase) |=> ninthDramAddressOut == videoRamAddress[17];
  endproperty
  a_a8_row: assert property (p_a8_row) else $error("A8 row bit wrong");

  property p_linear_direct;
    @(posedge sys_clk) disable iff (!rst_n)
    (st.memSize[5:4] != 2'b00) |-> linAddr == hostAddr;
  endproperty
  a_linear_direct: assert property (p_linear_direct) else $error("linear map offset");

  property p_page_subst;
    @(posedge sys_clk) disable iff (!rst_n)
    (widthMode == 2'b01 && !crtCycle && pageSubst)
      |=> videoRamAddress[0] == $past(invertedPageSelect);
  endproperty
  a_page_subst: assert property (p_page_subst) else $error("page select not used");

  property p_byte_crt;
    @(posedge sys_clk) disable iff (!rst_n)
    (widthMode == 2'b00 && crtCycle && isStd)
      |=> videoRamAddress[15:0] == $past(crtCharacterAddress[15:0]);
  endproperty
  a_byte_crt: assert property (p_byte_crt) else $error("byte CRT address wrong");

  property p_dword_std;
    @(posedge sys_clk) disable iff (!rst_n)
    (widthMode == 2'b10 && !crtCycle && isStd)
      |=> videoRamAddress[1:0] == $past(linAddr[15:14]);
  endproperty
  a_dword_std: assert property (p_dword_std) else $error("dword bits 1:0 wrong");

  property p_window_range;
    @(posedge sys_clk) disable iff (!rst_n)
    (st.memSize[5:4] == 2'b00 && hostAddr[19:17] != 3'h5) |=> !hostMemHit;
  endproperty
  a_window_range: assert property (p_window_range) else $error("hit outside window");
endmodule

// *** verif/vmam_far_side.sv ***
`timescale 1ns/10ps
module vmam_far_side (
  input wire logic [1:0] strapPullUp,
  output logic [1:0] memoryDataBus
);
  // each strap line has a resistor one way or the other; no line is ever left floating
  assign memoryDataBus = strapPullUp;
endmodule

// *** verif/vmam_tb.sv ***
`timescale 1ns/10ps
module testbench;
  logic sys_clk, rst_n, ioWrite, ioRead, crtCycle, planarGraphics, chainFour, dramRowPhase;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, secondMiscControl, graphicsMisc, miscOutput;
  logic ioRdHit, ninthDramAddressOut, hostMemHit, wideBusSelectN, biosRomSelect;
  logic [19:0] hostAddr;
  logic [17:0] crtCharacterAddress, videoRamAddress;
  logic [1:0] widthMode, memoryDataBus, strapPullUp;
  logic [7:0] mPrim, mAlt, mSize;
  logic [31:0] seed = 32'h00000055;
  int errTotal, cmpCount;

  vmam_far_side farSide (.strapPullUp(strapPullUp), .memoryDataBus(memoryDataBus));
  vmam_mapper DUT (.sys_clk(sys_clk), .rst_n(rst_n), .ioAddr(ioAddr), .ioWrite(ioWrite),
    .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdHit(ioRdHit),
    .hostAddr(hostAddr), .crtCycle(crtCycle), .crtCharacterAddress(crtCharacterAddress),
    .widthMode(widthMode), .secondMiscControl(secondMiscControl),
    .graphicsMisc(graphicsMisc), .miscOutput(miscOutput), .planarGraphics(planarGraphics),
    .chainFour(chainFour), .dramRowPhase(dramRowPhase), .memoryDataBus(memoryDataBus),
    .videoRamAddress(videoRamAddress), .ninthDramAddressOut(ninthDramAddressOut),
    .hostMemHit(hostMemHit), .wideBusSelectN(wideBusSelectN), .biosRomSelect(biosRomSelect));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [19:0] pickAddr(input logic [31:0] r);
    if (r[31:30] == 2'b00) return {5'b11000, r[14:0]};
    return r[29] ? r[19:0] : {3'b101, r[16:0]};
  endfunction

  function automatic logic [17:0] ramAddr(input logic [19:0] a, input logic crt,
      input logic [17:0] ca, input logic [1:0] wm, input logic [1:0] s);
    logic [17:0] m;
    if (wm == 2'b01) begin
      m = crt ? {ca[16:0], (s == 2'b11) ? ca[17] : ca[15]} : {a[17:1], (s == 2'b11) ? a[18] : a[16]};
    end else if (wm == 2'b10) begin
      m = crt ? {ca[15:0], (s == 2'b11) ? ca[17:16] : (s == 2'b00) ? ca[13:12] : ca[15:14]}
              : {a[17:2], (s == 2'b11) ? a[19:18] : (s == 2'b00) ? a[15:14] : a[17:16]};
    end else begin
      m = crt ? ca : a[17:0];
    end
    if (s != 2'b11) m[17] = 1'b0;
    if (s[1] == 1'b0) m[16] = 1'b0;
    // 512K: bit 16 is the bank bit, ca[16] on CRT cycles, else a higher host address bit as the width grows
    if (s == 2'b10) m[16] = crt ? ca[16] : a[16 + wm];
    return m;
  endfunction

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge sys_clk);
    ioWrite <= 1'b1;
    ioAddr <= vmam_pkg::IO_INDEX_PORT;
    ioWrData <= idx;
    @(posedge sys_clk);
    ioAddr <= vmam_pkg::IO_DATA_PORT;
    ioWrData <= val;
    @(posedge sys_clk);
    ioWrite <= 1'b0;
    if (idx == vmam_pkg::IDX_PRIMARY) mPrim = {1'b0, val[6:0]};
    if (idx == vmam_pkg::IDX_ALTERNATE) mAlt = {1'b0, val[6:0]};
    if (idx == vmam_pkg::IDX_MEMSIZE) mSize = val;
  endtask

  task automatic rd(input logic [7:0] idx, input logic hitExp, input logic [7:0] exp);
    @(posedge sys_clk);
    ioWrite <= 1'b1;
    ioAddr <= vmam_pkg::IO_INDEX_PORT;
    ioWrData <= idx;
    @(posedge sys_clk);
    ioWrite <= 1'b0;
    ioRead <= 1'b1;
    ioAddr <= vmam_pkg::IO_DATA_PORT;
    @(posedge sys_clk);
    ioRead <= 1'b0;
    #1;
    chk(20'(ioRdHit), 20'(hitExp));
    if (hitExp) chk(20'(ioRdData), 20'(exp));
  endtask

  task automatic do_reset(input logic [1:0] pu);
    strapPullUp <= pu;
    rst_n <= 1'b0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk({15'h0, hostMemHit, ninthDramAddressOut, biosRomSelect, ioRdHit, wideBusSelectN},
        20'h1);
    mPrim = 8'h00;
    mAlt = 8'h00;
    mSize = {6'h00, ~pu};
    rd(vmam_pkg::IDX_PRIMARY, 1'b1, 8'h00);
    rd(vmam_pkg::IDX_ALTERNATE, 1'b1, 8'h00);
    rd(vmam_pkg::IDX_MEMSIZE, 1'b1, mSize);
  endtask

  task automatic vec(input logic [31:0] r, input logic [19:0] a, input logic [17:0] ca);
    logic [19:0] rel, lin, lim;
    logic [17:0] ma;
    logic [1:0] wm, s, w;
    logic crt, hit, alt, nx;
    crt = r[0] & r[1];
    wm = (r[3:2] == 2'b11) ? 2'b00 : r[3:2];
    w = r[5:4];
    @(posedge sys_clk);
    hostAddr <= a;
    crtCharacterAddress <= ca;
    crtCycle <= crt;
    widthMode <= wm;
    graphicsMisc <= {4'h0, w, 2'b00};
    miscOutput <= {2'b00, r[6], 5'h00};
    planarGraphics <= r[7];
    chainFour <= r[8];
    dramRowPhase <= r[9];
    @(posedge sys_clk);
    #1;
    s = secondMiscControl[1] ? 2'b00 : mSize[7:6];
    rel = a - ((w[1] == 1'b0) ? 20'ha0000 : w[0] ? 20'hb8000 : 20'hb0000);
    lim = (w == 2'b00) ? 20'h1ffff : (w == 2'b01) ? 20'h0ffff : 20'h07fff;
    hit = !crt && rel <= lim;
    alt = (s != 2'b00) && mSize[3] && ((w == 2'b01) ? !rel[15] : (w == 2'b00) ? !rel[16] : 1'b0);
    lin = {{1'b0, rel[18:12]} + (alt ? mAlt : mPrim), rel[11:0]};
    // offsets only act in the extended table
    if (s == 2'b00) lin = rel;
    if (mSize[5:4] != 2'b00) begin
      lin = a;
      hit = !crt && (mSize[5] ? (mSize[4] || !a[19]) : (a[19:18] == 2'b00));
    end
    ma = ramAddr(lin, crt, ca, wm, s);
    if (!crt && wm == 2'b01 && w != 2'b00) ma[0] = ~r[6];
    nx = (s == 2'b10) ? ma[16] : (s == 2'b11) ? (r[9] ? ma[17] : ma[16]) : 1'b0;
    chk(20'(hostMemHit), 20'(hit));
    if (hit || crt) chk(20'(videoRamAddress), 20'(ma));
    if (hit || crt) chk(20'(ninthDramAddressOut), 20'(nx));
    chk(20'(wideBusSelectN), 20'(!(mSize[2] && !r[7] && hit)));
    if (!crt) chk(20'(biosRomSelect), 20'(a >= 20'hc0000 && a <= 20'hc7fff && !mSize[0]));
  endtask

  task automatic cfg();
    logic [31:0] r;
    logic [7:0] ms;
    r = rnd();
    ms = {r[7:2], mSize[1:0]};
    if (ms[5:4] != 2'b00) ms[7:6] = ms[5:4];
    @(posedge sys_clk);
    secondMiscControl <= {6'h00, ms[5:4] == 2'b00 && r[8], 1'b0};
    wr(vmam_pkg::IDX_PRIMARY, r[15:8]);
    wr(vmam_pkg::IDX_ALTERNATE, r[23:16]);
    wr(vmam_pkg::IDX_MEMSIZE, ms);
    rd(vmam_pkg::IDX_ALTERNATE, 1'b1, mAlt);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge sys_clk);
    errTotal++;
    complete_run();
  end

  initial begin
    {ioWrite, ioRead, crtCycle, planarGraphics, chainFour, dramRowPhase} = '0;
    {ioAddr, ioWrData, secondMiscControl, graphicsMisc, miscOutput} = '0;
    {hostAddr, crtCharacterAddress, widthMode} = '0;
    errTotal = 0;
    cmpCount = 0;
    do_reset(2'b01);
    wr(vmam_pkg::IDX_PRIMARY, 8'h81);
    wr(vmam_pkg::IDX_ALTERNATE, 8'h05);
    wr(vmam_pkg::IDX_MEMSIZE, {6'h12, mSize[1:0]});
    wr(8'h0c, 8'h33);
    rd(8'h0c, 1'b0, 8'h00);
    rd(vmam_pkg::IDX_PRIMARY, 1'b1, 8'h01);
    vec(32'h00000010, 20'ha8123, 18'h0);
    vec(32'h00000010, 20'ha0123, 18'h0);
    vec(32'h00000000, 20'hb0456, 18'h0);
    repeat (40) begin
      cfg();
      repeat (8) vec(rnd(), pickAddr(rnd()), 18'(rnd()));
    end
    @(posedge sys_clk);
    do_reset(2'b10);
    vec(32'h00000000, 20'hc1234, 18'h0);
    repeat (10) begin
      cfg();
      repeat (4) vec(rnd(), pickAddr(rnd()), 18'(rnd()));
    end
    complete_run();
  end
endmodule
